// [design/tec_error_counters_regs.vh]
`ifndef TEC_ERROR_COUNTERS_REGS_VH
`define TEC_ERROR_COUNTERS_REGS_VH

// register offsets on the parallel control port
`define TEC_LINE_HI_A 8'h23
`define TEC_LINE_LO_A 8'h24
`define TEC_PATH_HI_A 8'h25
`define TEC_PATH_LO_A 8'h26
`define TEC_LINE_HI_B 8'hc3
`define TEC_LINE_LO_B 8'hc4
`define TEC_PATH_HI_B 8'hc5
`define TEC_PATH_LO_B 8'hc6
`define TEC_MASK_TWO_B 8'hef

// event_mask_two_b fields
`define TEC_MASK_RX_MF 7
`define TEC_MASK_TX_MF 6
`define TEC_MASK_SEC 5
`define TEC_MASK_RX_FULL 4
`define TEC_MASK_TX_EMPTY 3
`define TEC_MASK_MATCH 2
`define TEC_MASK_ABORT 1
`define TEC_MASK_USED 8'hfe
`define TEC_MASK_RESET 8'h00

// counter limits
`define TEC_LINE_MAX 16'hffff
`define TEC_PATH_MAX 16'h0fff

// zero run thresholds
`define TEC_ZERO_RUN_PLAIN 5'h10
`define TEC_ZERO_RUN_SUBST 5'h08

// timing: intervals in ms, clock rate in kHz
`define TEC_SEC_MS 1000
`define TEC_SHORT_MS 42
`define TEC_CLK_KHZ 50000
// cycle counts below equal ms times kHz, kept sized to the 26-bit timer
`define TEC_SEC_CYCLES 26'h2faf080
`define TEC_SHORT_CYCLES 26'h0200b20

// synchronised pin vector layout
`define TEC_PIN_STROBE 0
`define TEC_PIN_ZERO 1
`define TEC_PIN_BPV 2
`define TEC_PIN_SUBST 3
`define TEC_PIN_CRC 4
`define TEC_PIN_FT 5
`define TEC_PIN_FS 6
`define TEC_PIN_LOST 7

`endif

// [design/tec_error_counters.v]
// Notes on behaviour
// - each framer latches its counts on one-second boundaries, or every 42 ms when the select is set.
// - with manual update enabled, counts latch only on the manual trigger, not on timer boundaries.
// - latched values stay unchanged for the whole interval until the next update.
// - every counter saturates at its maximum and never wraps.
// - line count is 16 bits, upper byte in the first register, lower byte in the second.
// - line count takes bipolar violations, plus 16 zeros (8 with substitution) when zero counting is on.
// - with substitution decoding on, valid substitution code words are not counted.
// - line count keeps counting while sync is lost.
// - in ESF mode the path count is a 12-bit count of CRC6 errors, whatever the Fs select says.
// - in D4 mode the path count takes Ft errors, plus Fs errors when the Fs select is set.
// - path count stops while sync is lost.
// - path count upper nibble is bits 3..0 of its first register, upper nibble is the shared count.
// - mask bits 7..1 gate rx multiframe, tx multiframe, second, rx full, tx empty, match, abort.
// - mask bit 0 blocks its source, 1 lets it raise the interrupt.
`timescale 1ns/1ps
`include "tec_error_counters_regs.vh"

module tec_framer_counts #(
    parameter [25:0] SEC_CYCLES = `TEC_SEC_CYCLES,
    parameter [25:0] SHORT_CYCLES = `TEC_SHORT_CYCLES
) (
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] pins,
    input wire update_interval_select,
    input wire manual_update_enable,
    input wire manual_update_trigger,
    input wire rx_zero_substitution_enable,
    input wire rx_framing_format_select,
    input wire excess_zero_count_enable,
    input wire fs_error_count_enable,
    output reg [15:0] line_hold_r,
    output reg [11:0] path_hold_r,
    output reg sec_tick_r
);

    // saturating add shared by both counters
    function [15:0] sat_add;
        input [15:0] v;
        input [1:0] inc;
        input [15:0] maxv;
        reg [16:0] sum;
        begin
            sum = {1'b0, v} + {15'h0000, inc};
            if (sum > {1'b0, maxv})
                sat_add = maxv;
            else
                sat_add = sum[15:0];
        end
    endfunction

    reg [7:0] meta_r;
    reg [7:0] sync_r;
    reg [7:0] prev_r;
    reg [25:0] timer_r;
    reg [4:0] zero_run_r;
    reg [15:0] line_run_r;
    reg [11:0] path_run_r;

    wire [7:0] rise;
    wire bit_ev;
    wire [4:0] zero_limit;
    wire ez_ev;
    wire bpv_ev;
    wire path_ev;
    wire timer_end;
    wire update;
    wire [25:0] limit;
    wire [15:0] line_base;
    wire [15:0] path_base;
    wire [15:0] path_sum;

    assign rise = sync_r & ~prev_r;
    assign bit_ev = rise[`TEC_PIN_STROBE];

    // a run of zeros counts once each time it reaches the threshold, then the run count restarts
    assign zero_limit = rx_zero_substitution_enable ? `TEC_ZERO_RUN_SUBST
                                                    : `TEC_ZERO_RUN_PLAIN;
    assign ez_ev = excess_zero_count_enable & bit_ev & sync_r[`TEC_PIN_ZERO]
                   & (zero_run_r == zero_limit - 5'h01);
    // substitution words carry deliberate violations
    assign bpv_ev = rise[`TEC_PIN_BPV]
                    & ~(rx_zero_substitution_enable & sync_r[`TEC_PIN_SUBST]);

    assign path_ev = ~sync_r[`TEC_PIN_LOST] &
                     (rx_framing_format_select ? rise[`TEC_PIN_CRC] :
                      (rise[`TEC_PIN_FT] | (fs_error_count_enable & rise[`TEC_PIN_FS])));

    assign limit = update_interval_select ? SHORT_CYCLES : SEC_CYCLES;
    assign timer_end = (timer_r >= limit - 26'h0000001);
    assign update = manual_update_enable ? manual_update_trigger : timer_end;

    // an event in the update cycle opens the new interval
    assign line_base = update ? 16'h0000 : line_run_r;
    assign path_base = update ? 16'h0000 : {4'h0, path_run_r};
    assign path_sum = sat_add(path_base, {1'b0, path_ev}, `TEC_PATH_MAX);

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 8'h00;
            sync_r <= 8'h00;
            prev_r <= 8'h00;
            timer_r <= 26'h0000000;
            zero_run_r <= 5'h00;
            line_run_r <= 16'h0000;
            path_run_r <= 12'h000;
            line_hold_r <= 16'h0000;
            path_hold_r <= 12'h000;
            sec_tick_r <= 1'b0;
        end
        else if (clk_en)
        begin
            meta_r <= pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
            // timer keeps running in manual mode so the second event still fires
            timer_r <= timer_end ? 26'h0000000 : timer_r + 26'h0000001;
            sec_tick_r <= timer_end;
            if (bit_ev)
            begin
                if (!sync_r[`TEC_PIN_ZERO] || zero_run_r == zero_limit - 5'h01)
                    zero_run_r <= 5'h00;
                else
                    zero_run_r <= zero_run_r + 5'h01;
            end
            // line count ignores sync loss
            line_run_r <= sat_add(line_base, {1'b0, bpv_ev} + {1'b0, ez_ev},
                                  `TEC_LINE_MAX);
            path_run_r <= path_sum[11:0];
            if (update)
            begin
                line_hold_r <= line_run_r;
                path_hold_r <= path_run_r;
            end
        end
    end

endmodule

module tec_error_counters #(
    parameter [25:0] SEC_CYCLES = `TEC_SEC_CYCLES,
    parameter [25:0] SHORT_CYCLES = `TEC_SHORT_CYCLES
) (
    input wire clk_sys,
    input wire arst_n,
    input wire clk_en,
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata_r,
    input wire rx_bit_strobe_a,
    input wire rx_bit_zero_a,
    input wire line_violation_bit_a,
    input wire rx_subst_word_a,
    input wire crc_error_a,
    input wire ft_error_a,
    input wire fs_error_a,
    input wire rx_sync_lost_a,
    input wire rx_bit_strobe_b,
    input wire rx_bit_zero_b,
    input wire line_violation_bit_b,
    input wire rx_subst_word_b,
    input wire crc_error_b,
    input wire ft_error_b,
    input wire fs_error_b,
    input wire rx_sync_lost_b,
    input wire update_interval_select_a,
    input wire manual_update_enable_a,
    input wire manual_update_trigger_a,
    input wire rx_zero_substitution_enable_a,
    input wire rx_framing_format_select_a,
    input wire excess_zero_count_enable_a,
    input wire fs_error_count_enable_a,
    input wire update_interval_select_b,
    input wire manual_update_enable_b,
    input wire manual_update_trigger_b,
    input wire rx_zero_substitution_enable_b,
    input wire rx_framing_format_select_b,
    input wire excess_zero_count_enable_b,
    input wire fs_error_count_enable_b,
    input wire [3:0] mos_nibble_a,
    input wire [3:0] mos_nibble_b,
    input wire rx_multiframe_event_b,
    input wire tx_multiframe_event_b,
    input wire rx_link_buffer_full_event_b,
    input wire tx_link_buffer_empty_event_b,
    input wire rx_link_match_event_b,
    input wire rx_link_abort_event_b,
    output wire one_second_status_flag_a,
    output wire one_second_status_flag_b,
    output wire int_req_b
);

    reg [1:0] rst_sync_r;
    reg [7:0] event_mask_two_b_r;
    reg [7:0] rdata_nxt;

    wire rst_n;
    wire [15:0] line_a;
    wire [15:0] line_b;
    wire [11:0] path_a;
    wire [11:0] path_b;
    wire [7:0] src_b;

    assign rst_n = rst_sync_r[1];

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    tec_framer_counts #(
        .SEC_CYCLES(SEC_CYCLES),
        .SHORT_CYCLES(SHORT_CYCLES)
    ) u_framer_a (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pins({rx_sync_lost_a, fs_error_a, ft_error_a, crc_error_a,
               rx_subst_word_a, line_violation_bit_a, rx_bit_zero_a, rx_bit_strobe_a}),
        .update_interval_select(update_interval_select_a),
        .manual_update_enable(manual_update_enable_a),
        .manual_update_trigger(manual_update_trigger_a),
        .rx_zero_substitution_enable(rx_zero_substitution_enable_a),
        .rx_framing_format_select(rx_framing_format_select_a),
        .excess_zero_count_enable(excess_zero_count_enable_a),
        .fs_error_count_enable(fs_error_count_enable_a),
        .line_hold_r(line_a),
        .path_hold_r(path_a),
        .sec_tick_r(one_second_status_flag_a)
    );

    tec_framer_counts #(
        .SEC_CYCLES(SEC_CYCLES),
        .SHORT_CYCLES(SHORT_CYCLES)
    ) u_framer_b (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pins({rx_sync_lost_b, fs_error_b, ft_error_b, crc_error_b,
               rx_subst_word_b, line_violation_bit_b, rx_bit_zero_b, rx_bit_strobe_b}),
        .update_interval_select(update_interval_select_b),
        .manual_update_enable(manual_update_enable_b),
        .manual_update_trigger(manual_update_trigger_b),
        .rx_zero_substitution_enable(rx_zero_substitution_enable_b),
        .rx_framing_format_select(rx_framing_format_select_b),
        .excess_zero_count_enable(excess_zero_count_enable_b),
        .fs_error_count_enable(fs_error_count_enable_b),
        .line_hold_r(line_b),
        .path_hold_r(path_b),
        .sec_tick_r(one_second_status_flag_b)
    );

    // interrupt sources lined up with the mask bits, bit 0 has no source
    assign src_b = {rx_multiframe_event_b, tx_multiframe_event_b, one_second_status_flag_b,
                    rx_link_buffer_full_event_b, tx_link_buffer_empty_event_b,
                    rx_link_match_event_b, rx_link_abort_event_b, 1'b0};
    assign int_req_b = |(src_b & event_mask_two_b_r);

    always @*
    begin
        case (bus_addr)
            `TEC_LINE_HI_A: rdata_nxt = line_a[15:8];
            `TEC_LINE_LO_A: rdata_nxt = line_a[7:0];
            `TEC_PATH_HI_A: rdata_nxt = {mos_nibble_a, path_a[11:8]};
            `TEC_PATH_LO_A: rdata_nxt = path_a[7:0];
            `TEC_LINE_HI_B: rdata_nxt = line_b[15:8];
            `TEC_LINE_LO_B: rdata_nxt = line_b[7:0];
            `TEC_PATH_HI_B: rdata_nxt = {mos_nibble_b, path_b[11:8]};
            `TEC_PATH_LO_B: rdata_nxt = path_b[7:0];
            `TEC_MASK_TWO_B: rdata_nxt = event_mask_two_b_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            event_mask_two_b_r <= `TEC_MASK_RESET;
            bus_rdata_r <= 8'h00;
        end
        else if (clk_en)
        begin
            // bit 0 is not stored, so a stray 1 there can never gate anything
            if (bus_wr && bus_addr == `TEC_MASK_TWO_B)
                event_mask_two_b_r <= bus_wdata & `TEC_MASK_USED;
            if (bus_rd)
                bus_rdata_r <= rdata_nxt;
        end
    end

endmodule

// [design/tec_dummy_unused.v]
`timescale 1ns/1ps

// [bench/tec_counts_monitor.sv]
`timescale 1ns/1ps
module tec_counts_monitor #(
    parameter [25:0] SEC_CYCLES = 26'h64,
    parameter [25:0] SHORT_CYCLES = 26'h14
) (
    input wire clk_sys,
    input wire arst_n,
    input wire clk_en,
    input wire [7:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [7:0] bus_rdata_r,
    input wire [3:0] mos_nibble_a,
    input wire update_interval_select_a,
    input wire one_second_status_flag_a
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    reg [7:0] mask_r;
    reg [25:0] gap_r;
    reg seen_r;
    wire rd_go = bus_rd && clk_en;
    wire hit = bus_addr inside {8'h23, 8'h24, 8'h25, 8'h26, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hef};
    wire flag = one_second_status_flag_a;
    wire sel = update_interval_select_a;
    // period only trusted once a full interval passed with a steady select
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_r <= 8'h00;
            gap_r <= 26'h0;
            seen_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (bus_wr && bus_addr == 8'hef)
                mask_r <= bus_wdata & 8'hfe;
            gap_r <= flag ? 26'h0 : gap_r + 26'h1;
            seen_r <= (seen_r || flag) && $stable(sel);
        end
    end
    a_mask_readback: assert property (
        rd_go && bus_addr == 8'hef |=> bus_rdata_r == $past(mask_r)) else $error("mask readback");
    a_mask_bit_zero: assert property (
        rd_go && bus_addr == 8'hef |=> !bus_rdata_r[0]) else $error("mask bit 0 set");
    a_unmapped_reads_zero: assert property (
        rd_go && !hit |=> bus_rdata_r == 8'h00) else $error("unmapped read not zero");
    a_path_nibble_shared: assert property (
        rd_go && bus_addr == 8'h25 |=> bus_rdata_r[7:4] == $past(mos_nibble_a))
        else $error("shared nibble wrong");
    a_rdata_holds: assert property (
        !rd_go |=> $stable(bus_rdata_r)) else $error("read data moved");
    a_flag_one_cycle: assert property (
        flag |=> !flag) else $error("flag longer than one cycle");
    a_second_period: assert property (
        flag && seen_r && $stable(sel) && !sel |-> gap_r == SEC_CYCLES - 26'h1)
        else $error("long interval wrong");
    a_short_period: assert property (
        flag && seen_r && $stable(sel) && sel |-> gap_r == SHORT_CYCLES - 26'h1)
        else $error("short interval wrong");
    cover property (flag && seen_r && sel);
    cover property (rd_go && bus_addr == 8'h25);
    cover property (bus_wr && bus_addr == 8'hef);
endmodule
bind tec_error_counters tec_counts_monitor #(.SEC_CYCLES(SEC_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)) u_tec_counts_monitor (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_en(clk_en), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r), .mos_nibble_a(mos_nibble_a),
    .update_interval_select_a(update_interval_select_a),
    .one_second_status_flag_a(one_second_status_flag_a));

// [bench/tec_host_model.sv]
`timescale 1ns/1ps
module tec_host_model (
    input wire clk_sys,
    input wire [7:0] bus_rdata_r,
    output reg [7:0] bus_addr,
    output reg [7:0] bus_wdata,
    output reg bus_wr,
    output reg bus_rd
);
    initial
        {bus_addr, bus_wdata, bus_wr, bus_rd} = 18'h0;
    task wr(input [7:0] a, input [7:0] dv);
    begin
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= (a == 8'hef) ? (dv & 8'hfe) : dv;
        bus_wr <= 1'b1;
        @(posedge clk_sys) bus_wr <= 1'b0;
    end
    endtask
    // data is registered, so it is taken 1 ns after the edge on which the strobe is seen
    task rd(input [7:0] a, output [7:0] dv);
    begin
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys) bus_rd <= 1'b0;
        #1 dv = bus_rdata_r;
    end
    endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    reg clk_sys = 1'b0;
    reg arst_n = 1'b0;
    reg ce = 1'b1;
    reg [7:0] p = 8'h00;
    reg [6:0] c = 7'h00;
    reg [5:0] ev = 6'h00;
    reg [3:0] mos = 4'h0;
    reg [7:0] d, e;
    wire [7:0] bus_addr, bus_wdata, bus_rdata_r;
    wire bus_wr, bus_rd, fa, fb, irq;
    integer n_errors = 0, n_tests = 0, line_m = 0, path_m = 0, zrun = 0, hl = 0, hp = 0, i, k, j;
    always #10 clk_sys = ~clk_sys;
    tec_host_model u_host (.clk_sys(clk_sys), .bus_rdata_r(bus_rdata_r), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd));
    // framer b mirrors framer a stimulus so both sets of counters are compared
    tec_error_counters #(.SEC_CYCLES(26'h64), .SHORT_CYCLES(26'h14)) u_tec_error_counters (
        .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(ce), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r),
        .rx_bit_strobe_a(p[0]), .rx_bit_zero_a(p[1]), .line_violation_bit_a(p[2]),
        .rx_subst_word_a(p[3]), .crc_error_a(p[4]), .ft_error_a(p[5]), .fs_error_a(p[6]),
        .rx_sync_lost_a(p[7]), .rx_bit_strobe_b(p[0]), .rx_bit_zero_b(p[1]),
        .line_violation_bit_b(p[2]), .rx_subst_word_b(p[3]), .crc_error_b(p[4]),
        .ft_error_b(p[5]), .fs_error_b(p[6]), .rx_sync_lost_b(p[7]),
        .update_interval_select_a(c[0]), .manual_update_enable_a(c[1]),
        .manual_update_trigger_a(c[2]), .rx_zero_substitution_enable_a(c[3]),
        .rx_framing_format_select_a(c[4]), .excess_zero_count_enable_a(c[5]),
        .fs_error_count_enable_a(c[6]), .update_interval_select_b(c[0]),
        .manual_update_enable_b(c[1]), .manual_update_trigger_b(c[2]),
        .rx_zero_substitution_enable_b(c[3]), .rx_framing_format_select_b(c[4]),
        .excess_zero_count_enable_b(c[5]), .fs_error_count_enable_b(c[6]),
        .mos_nibble_a(mos), .mos_nibble_b(mos), .rx_multiframe_event_b(ev[0]),
        .tx_multiframe_event_b(ev[1]), .rx_link_buffer_full_event_b(ev[2]),
        .tx_link_buffer_empty_event_b(ev[3]), .rx_link_match_event_b(ev[4]),
        .rx_link_abort_event_b(ev[5]), .one_second_status_flag_a(fa),
        .one_second_status_flag_b(fb), .int_req_b(irq));
    task complete_run;
    begin
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task cmp(input string nm, input [15:0] seen, input [15:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    // level pins settle well before the next pulse passes the synchronisers
    task lvl(input integer b, input v);
    begin
        repeat (4) @(posedge clk_sys);
        p[b] <= v;
    end
    endtask
    task pulse(input integer b);
    begin
        @(posedge clk_sys) p[b] <= 1'b1;
        @(posedge clk_sys) p[b] <= 1'b0;
        if (b == 2 && !(c[3] && p[3])) line_m++;
        if (b == 0) zrun = p[1] ? zrun + 1 : 0;
        if (b == 0 && c[5] && zrun == (c[3] ? 8 : 16))
        begin
            line_m++;
            zrun = 0;
        end
        if (!p[7] && (b == 4 && c[4] || b == 5 && !c[4] || b == 6 && !c[4] && c[6])) path_m++;
    end
    endtask
    task take;
    begin
        hl = line_m;
        hp = path_m;
        line_m = 0;
        path_m = 0;
    end
    endtask
    task upd;
    begin
        repeat (4) @(posedge clk_sys);
        c[2] <= 1'b1;
        @(posedge clk_sys) c[2] <= 1'b0;
        take;
    end
    endtask
    task tick;
    begin
        j = 0;
        do
        begin
            @(posedge clk_sys) #1;
            j++;
        end while (fa !== 1'b1 && j < 300);
        if (j == 300)
        begin
            n_errors++;
            complete_run;
        end
        if (!c[1]) take;
    end
    endtask
    task chk;
        for (k = 0; k < 2; k++)
        begin
            u_host.rd(k ? 8'hc3 : 8'h23, d);
            u_host.rd(k ? 8'hc4 : 8'h24, e);
            cmp("line", {d, e}, hl > 65535 ? 65535 : hl);
            u_host.rd(k ? 8'hc5 : 8'h25, d);
            u_host.rd(k ? 8'hc6 : 8'h26, e);
            cmp("path", {d[3:0], e}, hp > 4095 ? 4095 : hp);
            cmp("nibble", d[7:4], mos);
        end
    endtask
    initial
    begin
        d = $urandom(32'h779f);
        mos <= $urandom;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        u_host.rd(8'h30, d);
        cmp("unmapped", d, 16'h0000);
        u_host.wr(8'h23, 8'h55);
        for (i = 0; i < 16; i++)
        begin
            e = $urandom;
            u_host.wr(8'hef, e);
            ev <= $urandom;
            u_host.rd(8'hef, d);
            cmp("mask", d, e & 8'hfe);
            cmp("irq", irq, |(e[7:1] & {ev[0], ev[1], fb, ev[2], ev[3], ev[4], ev[5]}));
        end
        c <= 7'h02;
        for (i = 0; i < 4; i++)
        begin
            c[6:3] <= {i[0] ^ i[1], 1'b1, i[1], i[0]};
            lvl(1, 1'b1);
            repeat (17) pulse(0);
            lvl(1, 1'b0);
            pulse(0);
            lvl(3, 1'b1);
            pulse(2);
            lvl(3, 1'b0);
            repeat (2)
            begin
                pulse(2);
                for (k = 4; k < 7; k++) pulse(k);
                lvl(7, ~p[7]);
            end
            tick;
            chk;
            upd;
            chk;
        end
        c <= 7'h00;
        tick;
        repeat (3) pulse(2);
        tick;
        chk;
        chk;
        tick;
        chk;
        // frozen clock enable: these violations must never reach the counts
        ce <= 1'b0;
        repeat (3) pulse(2);
        line_m = line_m - 3;
        ce <= 1'b1;
        tick;
        chk;
        c <= 7'h12;
        repeat (4100) pulse(4);
        upd;
        chk;
        c <= 7'h01;
        repeat (3) tick;
        complete_run;
    end
endmodule
